/* File: logic/fpt_defines.svh */
`ifndef FPT_DEFINES_SVH
`define FPT_DEFINES_SVH

// ----------------------------------------------------------------
// clock and frequency limits
// ----------------------------------------------------------------
`define FPT_CLK_HZ        25'h1312D00
`define FPT_MAX_HS_HZ     17'h186A0
`define FPT_MAX_LS_HZ     17'h02710
`define FPT_MAX_STD_HZ    17'h00064

// ----------------------------------------------------------------
// widths, last quarter index and reset values
// ----------------------------------------------------------------
`define FPT_FREQ_W        17
`define FPT_STEP_W        19
`define FPT_ACC_W         25
`define FPT_CNT_W         32
`define FPT_QLAST         2'h3
`define FPT_SUPPLY_RST    1'h1

`endif

/* File: logic/fpt_pkg.sv */
package fpt_pkg;

    // ----------------------------------------------------------------
    // modes, signal types, states
    // ----------------------------------------------------------------
    typedef enum logic {
        FPT_FREQ_OUT,
        FPT_TRAIN
    } fpt_mode_type;

    typedef enum logic [1:0] {
        FPT_PULSE_DIR,
        FPT_UP_DOWN,
        FPT_QUAD_1X,
        FPT_QUAD_4X
    } fpt_sig_type;

    typedef enum logic [1:0] {
        FPT_IDLE,
        FPT_RUN,
        FPT_DONE
    } fpt_state_type;

    // ----------------------------------------------------------------
    // configuration and command carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        fpt_mode_type pulse_train_mode;
        fpt_sig_type  sig_type;
        logic         high_speed;
        logic         out_select;
        logic         diag_supply_en;
    } fpt_cfg_type;

    typedef struct packed {
        logic [16:0] freq_hz;
        logic        negative;
        logic [31:0] distance;
    } fpt_cmd_type;

endpackage

/* File: logic/fpt_sync.sv */
`timescale 1ns/1ns
`include "fpt_defines.svh"

module fpt_sync (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rstn,
    // pin side
    input  wire logic pin_in,
    // filtered level
    output logic      level
);

    logic s1;
    logic s2;
    logic s3;

    // ----------------------------------------------------------------
    // three stages, change taken when stages two and three agree
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s1    <= `FPT_SUPPLY_RST;
            s2    <= `FPT_SUPPLY_RST;
            s3    <= `FPT_SUPPLY_RST;
            level <= `FPT_SUPPLY_RST;
        end else begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end

endmodule // fpt_sync

/* File: logic/fpt_tick_gen.sv */
`timescale 1ns/1ns
`include "fpt_defines.svh"

module fpt_tick_gen (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rstn,
    // control
    input  wire logic                   clear,
    input  wire logic [`FPT_STEP_W-1:0] step,
    // quarter-period enable
    output logic                        tick
);

    logic [`FPT_ACC_W-1:0] acc;
    logic [`FPT_ACC_W-1:0] sum;

    assign sum = acc + {{(`FPT_ACC_W-`FPT_STEP_W){1'b0}}, step};

    // ----------------------------------------------------------------
    // phase accumulator, one pulse per step hertz
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            acc  <= '0;
            tick <= 1'b0;
        end else if (clear) begin
            acc  <= '0;
            tick <= 1'b0;
        end else if (sum >= `FPT_CLK_HZ) begin
            acc  <= sum - `FPT_CLK_HZ;
            tick <= 1'b1;
        end else begin
            acc  <= sum;
            tick <= 1'b0;
        end
    end

endmodule // fpt_tick_gen

/* File: logic/fpt_channel.sv */
`timescale 1ns/1ns
`include "fpt_defines.svh"

module fpt_channel
    import fpt_pkg::*;
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rstn,
    // configuration and command
    input  wire fpt_pkg::fpt_cfg_type cfg,
    input  wire fpt_pkg::fpt_cmd_type cmd,
    input  wire logic                 sw_run_request,
    // supply monitor pin and diagnostic clear
    input  wire logic                 supply_ok_pin,
    input  wire logic                 diag_clear,
    // pulse pins
    output logic                      pulse_out_a,
    output logic                      pulse_out_std,
    output logic                      pulse_out_b,
    // feedback
    output logic                      run_active_flag,
    output logic                      move_done,
    output logic                      diag_irq
);
    import fpt_pkg::*;

    fpt_state_type          state;
    logic                   run_req_d;
    logic                   run_rise;
    logic                   qtick;
    logic [1:0]             quarter;
    logic                   period_start;
    logic [`FPT_FREQ_W-1:0] freq_lim;
    logic [`FPT_FREQ_W-1:0] freq_max;
    logic [`FPT_FREQ_W-1:0] freq_cur;
    logic [`FPT_CNT_W-1:0]  remaining;
    logic                   dir_neg;
    logic                   supply_ok;
    logic                   supply_ok_d;
    logic                   next_a;
    logic                   next_b;
    logic                   wave_a;

    assign run_rise     = sw_run_request && !run_req_d;
    assign period_start = qtick && (quarter == `FPT_QLAST);
    assign wave_a       = pulse_out_a || pulse_out_std;

    // ----------------------------------------------------------------
    // submodules
    // ----------------------------------------------------------------
    fpt_sync u_supply_sync (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .pin_in  (supply_ok_pin),
        .level   (supply_ok)
    );

    fpt_tick_gen u_tick (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .clear   (state != FPT_RUN),
        .step    ({(period_start ? freq_lim : freq_cur), 2'b00}),
        .tick    (qtick)
    );

    // ----------------------------------------------------------------
    // frequency limit and setpoint
    // ----------------------------------------------------------------
    always_comb begin
        if (cfg.out_select) begin
            freq_max = `FPT_MAX_STD_HZ;
        end else if (cfg.high_speed) begin
            freq_max = `FPT_MAX_HS_HZ;
        end else begin
            freq_max = `FPT_MAX_LS_HZ;
        end
        freq_lim = (cmd.freq_hz > freq_max) ? freq_max : cmd.freq_hz;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            freq_cur <= '0;
            dir_neg  <= 1'b0;
        end else if (run_rise || period_start) begin
            freq_cur <= freq_lim;
            dir_neg  <= cmd.negative;
        end
    end

    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            run_req_d <= 1'b0;
        end else begin
            run_req_d <= sw_run_request;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state <= FPT_IDLE;
        end else if (!sw_run_request) begin
            state <= FPT_IDLE;
        end else begin
            case (state)
                FPT_IDLE: begin
                    if (run_rise) begin
                        if (cfg.pulse_train_mode == FPT_TRAIN && cmd.distance == '0) begin
                            state <= FPT_DONE;
                        end else begin
                            state <= FPT_RUN;
                        end
                    end
                end
                FPT_RUN: begin
                    if (cfg.pulse_train_mode == FPT_TRAIN && remaining == 32'h00000001) begin
                        if (cfg.sig_type == FPT_QUAD_4X ? qtick : period_start) begin
                            state <= FPT_DONE;
                        end
                    end
                end
                default: begin
                    state <= state;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            run_active_flag <= 1'b0;
        end else if (!sw_run_request) begin
            run_active_flag <= 1'b0;
        end else if (run_rise) begin
            run_active_flag <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            move_done <= 1'b0;
        end else begin
            move_done <= sw_run_request && (state == FPT_DONE);
        end
    end

    // ----------------------------------------------------------------
    // quarter phase and distance count
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            quarter <= 2'h0;
        end else if (run_rise) begin
            quarter <= 2'h0;
        end else if (state == FPT_RUN && qtick) begin
            quarter <= quarter + 2'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            remaining <= '0;
        end else if (run_rise) begin
            remaining <= cmd.distance;
        end else if (state == FPT_RUN) begin
            if (cfg.sig_type == FPT_QUAD_4X && qtick) begin
                remaining <= remaining - 32'h00000001;
            end else if (cfg.sig_type != FPT_QUAD_4X && period_start) begin
                remaining <= remaining - 32'h00000001;
            end
        end
    end

    // ----------------------------------------------------------------
    // waveform shaping
    // ----------------------------------------------------------------
    always_comb begin
        next_a = 1'b0;
        next_b = 1'b0;
        if (cfg.pulse_train_mode == FPT_FREQ_OUT) begin
            next_a = quarter[1];
        end else begin
            case (cfg.sig_type)
                FPT_PULSE_DIR: begin
                    next_a = quarter[1];
                    next_b = dir_neg;
                end
                FPT_UP_DOWN: begin
                    next_a = quarter[1] && !dir_neg;
                    next_b = quarter[1] && dir_neg;
                end
                default: begin
                    next_a = dir_neg ? (quarter[1] ^ quarter[0]) : (quarter == 2'h1 || quarter == 2'h2);
                    next_b = dir_neg ? (quarter == 2'h1 || quarter == 2'h2) : (quarter[1] ^ quarter[0]);
                    if (!dir_neg) begin
                        next_b = quarter[1];
                    end else begin
                        next_a = quarter[1];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pulse_out_a   <= 1'b0;
            pulse_out_std <= 1'b0;
            pulse_out_b   <= 1'b0;
        end else if (!sw_run_request || state == FPT_IDLE) begin
            pulse_out_a   <= 1'b0;
            pulse_out_std <= 1'b0;
            pulse_out_b   <= 1'b0;
        end else begin
            pulse_out_a   <= !cfg.out_select && next_a;
            pulse_out_std <= cfg.out_select && next_a;
            pulse_out_b   <= next_b;
        end
    end

    // ----------------------------------------------------------------
    // supply diagnostics
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            supply_ok_d <= `FPT_SUPPLY_RST;
        end else begin
            supply_ok_d <= supply_ok;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            diag_irq <= 1'b0;
        end else if (cfg.diag_supply_en && supply_ok_d && !supply_ok) begin
            diag_irq <= 1'b1;
        end else if (diag_clear) begin
            diag_irq <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_run_rise;
        sw_run_request && !run_req_d;
    endsequence

    sequence s_all_low;
        !run_active_flag && !pulse_out_a && !pulse_out_std && !pulse_out_b;
    endsequence

    property p_stop;
        @(posedge sys_clk) disable iff (!rstn) !sw_run_request |=> s_all_low;
    endproperty
    a_stop: assert property (p_stop) else $error("outputs not cleared after run request fell");

    property p_start;
        @(posedge sys_clk) disable iff (!rstn) s_run_rise |=> run_active_flag;
    endproperty
    a_start: assert property (p_start) else $error("run flag not set on run request rise");

    property p_hold_setpoint;
        @(posedge sys_clk) disable iff (!rstn) (state == FPT_RUN && !period_start && sw_run_request) |=> $stable(freq_cur);
    endproperty
    a_hold_setpoint: assert property (p_hold_setpoint) else $error("setpoint changed inside a period");

    property p_limit_std;
        @(posedge sys_clk) disable iff (!rstn) cfg.out_select |-> freq_lim <= `FPT_MAX_STD_HZ;
    endproperty
    a_limit_std: assert property (p_limit_std) else $error("standard output above 100 Hz");

    property p_limit_hs;
        @(posedge sys_clk) disable iff (!rstn) !cfg.high_speed |-> freq_lim <= `FPT_MAX_LS_HZ;
    endproperty
    a_limit_hs: assert property (p_limit_hs) else $error("frequency above 10 kHz without high speed");

    property p_select;
        @(posedge sys_clk) disable iff (!rstn) cfg.out_select |=> !pulse_out_a;
    endproperty
    a_select: assert property (p_select) else $error("fast output driven while standard output selected");

    property p_quad_lead;
        @(posedge sys_clk) disable iff (!rstn)
            (cfg.pulse_train_mode == FPT_TRAIN && cfg.sig_type[1] && !dir_neg && $rose(pulse_out_b)) |-> wave_a;
    endproperty
    a_quad_lead: assert property (p_quad_lead) else $error("phase B rose ahead of A in positive motion");

    property p_updown;
        @(posedge sys_clk) disable iff (!rstn)
            (cfg.pulse_train_mode == FPT_TRAIN && cfg.sig_type == FPT_UP_DOWN) |-> !(pulse_out_b && wave_a);
    endproperty
    a_updown: assert property (p_updown) else $error("up and down pulses at once");

    property p_dir_settle;
        @(posedge sys_clk) disable iff (!rstn)
            (cfg.pulse_train_mode == FPT_TRAIN && cfg.sig_type == FPT_PULSE_DIR && $rose(wave_a)) |-> $stable(pulse_out_b);
    endproperty
    a_dir_settle: assert property (p_dir_settle) else $error("direction moved with the pulse edge");

    property p_count_4x;
        @(posedge sys_clk) disable iff (!rstn)
            (state == FPT_RUN && sw_run_request && cfg.sig_type == FPT_QUAD_4X && qtick)
            |=> remaining == $past(remaining) - 32'h00000001;
    endproperty
    a_count_4x: assert property (p_count_4x) else $error("4x increment not counted per edge");

    property p_diag;
        @(posedge sys_clk) disable iff (!rstn) (cfg.diag_supply_en && supply_ok_d && !supply_ok) |=> diag_irq;
    endproperty
    a_diag: assert property (p_diag) else $error("supply loss did not raise diagnostic");

endmodule // fpt_channel

/* File: verif/fpt_drive_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// drive input: decodes the two pins into a signed position
// ----------------------------------------------------------------
module fpt_drive_model (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rstn,
    // decoder setup and pins
    input  wire fpt_pkg::fpt_sig_type sig,
    input  wire logic                 run,
    input  wire logic                 a,
    input  wire logic                 b,
    // decoded position and edge faults
    output logic signed [31:0]        pos,
    output logic [7:0]                fault
);
    import fpt_pkg::*;

    logic pa;
    logic pb;

    // quadrature state index, positive order 00 10 11 01
    function automatic logic [1:0] gidx(input logic x, input logic y);
        return {y, x ^ y};
    endfunction

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pa    <= 1'h0;
            pb    <= 1'h0;
            pos   <= 32'sh0;
            fault <= 8'h00;
        end else begin
            pa <= a;
            pb <= b;
            // both pins moving together, or direction moving on a pulse
            if (run && a != pa && b != pb && (sig[1] || a))
                fault <= fault + 8'h01;
            case (sig)
                FPT_PULSE_DIR, FPT_QUAD_1X: begin
                    if (a && !pa)
                        pos <= b ? pos - 32'sh1 : pos + 32'sh1;
                end
                FPT_UP_DOWN: begin
                    if (a && !pa)
                        pos <= pos + 32'sh1;
                    else if (b && !pb)
                        pos <= pos - 32'sh1;
                end
                default: begin
                    case (gidx(a, b) - gidx(pa, pb))
                        2'h1:    pos <= pos + 32'sh1;
                        2'h3:    pos <= pos - 32'sh1;
                        default: pos <= pos;
                    endcase
                end
            endcase
        end
    end
endmodule // fpt_drive_model

/* File: verif/tb_frequency_and_pulse_train_output.sv */
`timescale 1ns/1ns
module tb_frequency_and_pulse_train_output;
    import fpt_pkg::*;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic               sys_clk;
    logic               rstn;
    fpt_cfg_type        cfg;
    fpt_cmd_type        cmd;
    logic               sw_run_request;
    logic               supply_ok_pin;
    logic               diag_clear;
    logic               pulse_out_a;
    logic               pulse_out_std;
    logic               pulse_out_b;
    logic               run_active_flag;
    logic               move_done;
    logic               diag_irq;
    logic signed [31:0] pos;
    logic signed [31:0] p0;
    logic [7:0]         fault;
    logic               seen;
    int                 err_count;
    int                 compares;
    int                 seed;
    int                 hi;
    int                 lo;
    int                 n;
    int                 ft[3] = '{100000, 100000, 4000};
    logic               hs[3] = '{1'h1, 1'h0, 1'h0};

    fpt_channel i_fpt_channel (
        .sys_clk(sys_clk), .rstn(rstn), .cfg(cfg), .cmd(cmd),
        .sw_run_request(sw_run_request), .supply_ok_pin(supply_ok_pin),
        .diag_clear(diag_clear), .pulse_out_a(pulse_out_a),
        .pulse_out_std(pulse_out_std), .pulse_out_b(pulse_out_b),
        .run_active_flag(run_active_flag), .move_done(move_done),
        .diag_irq(diag_irq));

    fpt_drive_model i_fpt_drive_model (
        .sys_clk(sys_clk), .rstn(rstn), .sig(cfg.sig_type),
        .run(run_active_flag), .a(pulse_out_a), .b(pulse_out_b),
        .pos(pos), .fault(fault));

    initial begin
        sys_clk = 1'h0;
        forever #25 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------------
    // tasks and expectations
    // ----------------------------------------------------------------
    task automatic give_verdict();
        if (err_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string m);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    task automatic chk_num(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %0d exp %0d", $time, m, got, exp);
        end
    endtask

    task automatic step();
        @(posedge sys_clk);
        #5;
    endtask

    task automatic fail(input string m);
        err_count++;
        $display("wrong value at %0t: %s", $time, m);
        give_verdict();
    endtask

    task automatic wait_a(input logic lvl, output int c);
        c = 0;
        while (pulse_out_a !== lvl) begin
            step();
            c++;
            if (c > 6000)
                fail("pulse wait timeout");
        end
    endtask

    task automatic start();
        chk_bit(run_active_flag, 1'h0, "active before run");
        sw_run_request = 1'h1;
        step();
        step();
        chk_bit(run_active_flag, 1'h1, "active after run rise");
    endtask

    task automatic stop();
        sw_run_request = 1'h0;
        step();
        step();
        chk_bit(run_active_flag | pulse_out_a | pulse_out_std | pulse_out_b, 1'h0, "stop");
    endtask

    function automatic int exp_half(input int f, input logic h);
        return 10000000 / ((!h && f > 10000) ? 10000 : f);
    endfunction

    function automatic logic [31:0] exp_pos(input logic [31:0] d, input logic neg);
        return neg ? -d : d;
    endfunction

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed           = 32'h7702;
        err_count      = 0;
        compares       = 0;
        rstn           = 1'h0;
        cfg            = '0;
        cmd            = '0;
        sw_run_request = 1'h0;
        supply_ok_pin  = 1'h1;
        diag_clear     = 1'h0;
        repeat (20) @(posedge sys_clk);
        #5 rstn = 1'h1;
        step();
        chk_bit(run_active_flag | pulse_out_a | pulse_out_std | pulse_out_b | move_done | diag_irq, 1'h0, "reset outputs");
        // frequency mode: period, duty and clamping
        for (int i = 0; i < 3; i++) begin
            cfg.high_speed = hs[i];
            cmd.freq_hz    = 17'(ft[i]);
            start();
            wait_a(1'h1, n);
            wait_a(1'h0, hi);
            wait_a(1'h1, lo);
            chk_num(hi, exp_half(ft[i], hs[i]), "high time");
            chk_num(lo, exp_half(ft[i], hs[i]), "low time");
            chk_bit(pulse_out_b, 1'h0, "b in frequency mode");
            chk_bit(pulse_out_std, 1'h0, "standard pin idle");
            stop();
        end
        // setpoint change in mid-period
        cfg.high_speed = 1'h1;
        cmd.freq_hz    = 17'h186A0;
        start();
        wait_a(1'h1, n);
        cmd.freq_hz = 17'h0C350;
        wait_a(1'h0, hi);
        wait_a(1'h1, lo);
        chk_num(hi, 100, "old period kept");
        chk_num(lo, 200, "new period low");
        stop();
        // standard output selected: fast pin stays quiet
        cfg.out_select = 1'h1;
        cmd.freq_hz    = 17'h00064;
        start();
        seen = 1'h0;
        repeat (300) begin
            step();
            seen = seen | pulse_out_a;
        end
        chk_bit(seen, 1'h0, "fast pin idle");
        stop();
        // pulse train: every type, both directions, random extras
        cfg.out_select       = 1'h0;
        cfg.pulse_train_mode = FPT_TRAIN;
        for (int k = 0; k < 10; k++) begin
            n              = $random(seed);
            cfg.sig_type   = fpt_sig_type'(k < 8 ? k % 4 : n & 3);
            cmd.negative   = k < 8 ? k >= 4 : n[4];
            cmd.distance   = k == 9 ? 32'h0 : 32'(1 + ((n >> 8) & 7));
            cmd.freq_hz    = n[12] ? 17'h186A0 : 17'h0C350;
            p0             = pos;
            start();
            n = 0;
            while (move_done !== 1'h1) begin
                step();
                n++;
                if (n > 20000)
                    fail("move timeout");
            end
            repeat (3) step();
            chk_num(pos - p0, exp_pos(cmd.distance, cmd.negative), "distance");
            chk_num(fault, 0, "edge spacing");
            if (cfg.sig_type == FPT_PULSE_DIR)
                chk_bit(pulse_out_b, cmd.negative, "direction level");
            stop();
        end
        // supply loss diagnostic
        supply_ok_pin = 1'h0;
        repeat (10) step();
        chk_bit(diag_irq, 1'h0, "diag disabled");
        supply_ok_pin = 1'h1;
        repeat (8) step();
        cfg.diag_supply_en = 1'h1;
        step();
        supply_ok_pin = 1'h0;
        repeat (8) step();
        chk_bit(diag_irq, 1'h1, "diag raised");
        supply_ok_pin = 1'h1;
        repeat (8) step();
        diag_clear = 1'h1;
        step();
        diag_clear = 1'h0;
        step();
        chk_bit(diag_irq, 1'h0, "diag cleared");
        give_verdict();
    end
endmodule // tb_frequency_and_pulse_train_output
